/* core/rx_word_aligner_pkg.sv */
// Constants, register map and field layout of the receive word aligner
// Contract
// - Bit-order reversal mirrors the output word, for 8-bit and 10-bit words
// - Reversal works only in basic mode with the bit-slip aligner
// - Polarity inversion acts on data entering the aligner, not the decoder
// - 8-bit manual aligner is edge sensitive, 10-bit is level sensitive
// - 8-bit search starts only on an enable rise after reset release
// - Framing pattern 16'hF628 with select low, 32'hF6F62828 with it high
// - Basic 8-bit manual alignment uses a configurable 16-bit pattern
// - 10-bit: enable high searches and moves to any new boundary
// - 10-bit: enable low keeps the boundary despite patterns elsewhere
// - Status outputs share the data path latency
// - 8-bit: first pattern after enable rise pulses sync and detect together, one cycle
// - Later patterns at the same boundary pulse only pattern detect
// - Realign only after enable rise (8-bit) or enable high (10-bit)
// - Double width locks to first match after reset, whatever the enable
// - Double width ignores other boundaries; user raises enable to realign
// - Double width sync falls some cycles after enable asserts
// - Bit-slip: 10-bit takes 7 or 10-bit pattern, 8-bit only 16-bit
// - Each slip request rise shifts the boundary by exactly one bit
// - Bit-slip pulses pattern detect whenever slipped data matches
// - Polarity invert high inverts every bit of every incoming word
// - Reset clears the aligner and all its alignment state
// - Double width sync stays high, drops on enable rise until new match
package rx_word_aligner_pkg;
  localparam int          DATA_W      = 20;
  localparam int          HIST_W      = 64;
  localparam int          BND_W       = 5;
  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  PATTERN_OFS = 8'h04;
  localparam logic [7:0]  STATUS_OFS  = 8'h08;
  // Control field positions
  localparam int          CTRL_SLIP   = 0;
  localparam int          CTRL_WIDTH  = 1;   // 2 bits
  localparam int          CTRL_PLEN   = 3;   // 3 bits
  localparam int          CTRL_SONET  = 6;
  localparam int          CTRL_BASIC  = 7;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0080;
  localparam logic [31:0] PAT_RESET   = 32'h0000_0000;
  // Width codes
  localparam logic [1:0]  WID_8       = 2'h0;
  localparam logic [1:0]  WID_10      = 2'h1;
  localparam logic [1:0]  WID_16      = 2'h2;
  localparam logic [1:0]  WID_20      = 2'h3;
  // Framing patterns, first received byte is the most significant
  localparam logic [15:0] FRAME_16    = 16'hF628;
  localparam logic [31:0] FRAME_32    = 32'hF6F6_2828;
  // Bus transfer type bit that marks NONSEQ or SEQ
  localparam int          HTRANS_ACT  = 1;
endpackage

/* core/rx_word_aligner.sv */
// Receive word aligner with manual and bit-slip modes and AHB-Lite control
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
module rx_word_aligner
  import rx_word_aligner_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic      [31:0]         hrdata,
  input  wire logic [DATA_W-1:0]   rx_word,
  input  wire logic                polarity_invert,
  input  wire logic                bit_order_reverse,
  input  wire logic                align_enable,
  input  wire logic                slip_request,
  input  wire logic                framing_size_select,
  output logic      [DATA_W-1:0]   data_out,
  output logic                     sync_status,
  output logic                     pattern_detect
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Word width in bits from its code
  function automatic logic [BND_W-1:0] width_of(input logic [1:0] code);
    case (code)
      WID_8:   width_of = 5'd8;
      WID_10:  width_of = 5'd10;
      WID_16:  width_of = 5'd16;
      default: width_of = 5'd20;
    endcase
  endfunction

  // Pattern length in bits from its code
  function automatic logic [5:0] plen_of(input logic [2:0] code);
    case (code)
      3'd0:    plen_of = 6'd7;
      3'd1:    plen_of = 6'd8;
      3'd2:    plen_of = 6'd10;
      3'd3:    plen_of = 6'd16;
      3'd4:    plen_of = 6'd20;
      default: plen_of = 6'd32;
    endcase
  endfunction

  // Low n bits set
  function automatic logic [HIST_W-1:0] lowmask(input logic [6:0] n);
    lowmask = ~({HIST_W{1'b1}} << n);
  endfunction

  // Mirror the low 8 or 10 bits of a word
  function automatic logic [DATA_W-1:0] mirror(input logic [DATA_W-1:0] d,
                                               input logic             ten);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < 10; i++) begin
      if (ten) begin
        r[i] = d[9-i];
      end else if (i < 8) begin
        r[i] = d[7-i];
      end
    end
    mirror = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file over AHB-Lite

  logic [31:0]  ctrl;
  logic [31:0]  pattern;
  logic         wr_pend;
  logic [7:0]   wr_ofs;
  logic         addr_take;
  logic [31:0]  status_word;

  assign hreadyout = ce;     // Bus stalls while the block is frozen
  assign hresp     = 1'b0;   // Always OKAY
  assign addr_take = ce & hsel & hready & htrans[HTRANS_ACT];

  // Address phase capture for writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_ofs  <= '0;
    end else if (ce) begin
      wr_pend <= addr_take & hwrite;
      wr_ofs  <= haddr[7:0];
    end
  end

  // Data phase write of the configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl    <= CTRL_RESET;
      pattern <= PAT_RESET;
    end else if (ce && wr_pend) begin
      if (wr_ofs == CTRL_OFS) ctrl <= hwdata & 32'h0000_00FF;
      if (wr_ofs == PATTERN_OFS) pattern <= hwdata;
    end
  end

  // Read data is sampled in the address phase; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= '0;
    end else if (ce && addr_take && !hwrite) begin
      case (haddr[7:0])
        CTRL_OFS:    hrdata <= ctrl;
        PATTERN_OFS: hrdata <= pattern;
        STATUS_OFS:  hrdata <= status_word;
        default:     hrdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode

  logic             slip_mode;
  logic             sonet;
  logic             basic;
  logic [1:0]       wcode;
  logic [BND_W-1:0] wbits;
  logic [5:0]       plen;
  logic [31:0]      pat_cmp;
  logic             dbl;
  logic             w8;

  assign slip_mode = ctrl[CTRL_SLIP];
  assign sonet     = ctrl[CTRL_SONET] & ~slip_mode;
  assign basic     = ctrl[CTRL_BASIC];
  assign wcode     = ctrl[CTRL_WIDTH +: 2];
  assign wbits     = width_of(wcode);
  assign dbl       = wcode[1];
  assign w8        = (wcode == WID_8);

  // Pattern and its length; framing bytes arrive most significant first
  always_comb begin
    if (sonet && framing_size_select) begin
      plen    = 6'd32;
      pat_cmp = {FRAME_32[7:0], FRAME_32[15:8],
                 FRAME_32[23:16], FRAME_32[31:24]};
    end else if (sonet) begin
      plen    = 6'd16;
      pat_cmp = {16'h0000, FRAME_16[7:0], FRAME_16[15:8]};
    end else if (w8) begin
      plen    = 6'd16;
      pat_cmp = pattern;
    end else begin
      plen    = plen_of(ctrl[CTRL_PLEN +: 3]);
      pat_cmp = pattern;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning and history

  logic [DATA_W-1:0] word_in;
  logic [HIST_W-1:0] hist;
  logic [HIST_W-1:0] next_hist;

  // Invert every valid bit ahead of the aligner
  assign word_in = (polarity_invert ? ~rx_word : rx_word)
                   & DATA_W'(lowmask({2'b00, wbits}));

  // Oldest bits sit low; each word enters at the top
  always_comb begin
    next_hist = (hist >> wbits)
              | ({{(HIST_W-DATA_W){1'b0}}, word_in} << (7'(HIST_W) - wbits));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hist <= '0;
    end else if (ce) begin
      hist <= next_hist;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on enable and slip request

  logic en_q;
  logic slip_q;
  logic en_rise;
  logic slip_rise;

  // Enable sample starts high so a level held through reset is no edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_q   <= 1'b1;
      slip_q <= 1'b1;
    end else if (ce) begin
      en_q   <= align_enable;
      slip_q <= slip_request;
    end
  end

  assign en_rise   = align_enable & ~en_q;
  assign slip_rise = slip_request & ~slip_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pattern search over every boundary

  logic [BND_W-1:0]  boundary;
  logic [DATA_W-1:0] hit;
  logic              any_hit;
  logic              cur_hit;
  logic [BND_W-1:0]  first_b;
  logic [BND_W-1:0]  sel_b;
  logic [6:0]        base;

  // Word for boundary b spans bits base+b upward in the last two words
  always_comb begin
    logic [6:0] start;
    start   = '0;
    base    = 7'(HIST_W) - 7'({wbits, 1'b0});
    hit     = '0;
    any_hit = 1'b0;
    first_b = '0;
    for (int b = DATA_W - 1; b >= 0; b--) begin
      if (b < wbits) begin
        if (plen <= {1'b0, wbits}) begin
          start = base + 7'(b);
        end else begin
          start = base + 7'(b) + {2'b00, wbits} - {1'b0, plen};
        end
        if (((hist >> start) & lowmask({1'b0, plen}))
            == ({32'h0, pat_cmp} & lowmask({1'b0, plen}))) begin
          hit[b]  = 1'b1;
          any_hit = 1'b1;
          first_b = BND_W'(b);
        end
      end
    end
  end

  assign cur_hit = hit[boundary];
  assign sel_b   = cur_hit ? boundary : first_b;

  ////////////////////////////////////////////////////////////////////////////
  // Alignment control

  logic armed;
  logic locked;
  logic sync_level;
  logic realign_ok;
  logic take;
  logic next_sync_pulse;
  logic next_pd;

  // 10-bit follows the enable level, double width searches until first
  // lock, others need an armed search
  assign realign_ok = (wcode == WID_10) ? align_enable
                    : dbl ? (armed | ~locked)
                          : armed;
  assign take = ~slip_mode & any_hit & realign_ok;

  // Status pulses for the word leaving this cycle
  always_comb begin
    next_sync_pulse = 1'b0;
    next_pd         = 1'b0;
    if (slip_mode) begin
      next_pd = cur_hit;
    end else if (take) begin
      next_pd         = 1'b1;
      next_sync_pulse = armed | ~locked | (sel_b != boundary);
    end else if (locked && cur_hit) begin
      next_pd = 1'b1;
    end
  end

  // Boundary and lock state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boundary <= '0;
      locked   <= 1'b0;
    end else if (ce) begin
      if (slip_mode) begin
        if (slip_rise) begin
          boundary <= (boundary >= wbits - 5'd1) ? '0 : boundary + 5'd1;
        end
      end else if (take) begin
        boundary <= sel_b;
        locked   <= 1'b1;
      end
    end
  end

  // Armed only by an enable rise; reset leaves the search disarmed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (ce) begin
      if (en_rise) begin
        armed <= 1'b1;
      end else if (take || (!dbl && !w8)) begin
        armed <= (take ? 1'b0 : armed) & w8;
      end
    end
  end

  // Double width sync level: set on lock, dropped by an enable rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_level <= 1'b0;
    end else if (ce) begin
      if (en_rise) begin
        sync_level <= 1'b0;
      end else if (take) begin
        sync_level <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage, data and status registered together

  logic [BND_W-1:0]  out_b;
  logic [DATA_W-1:0] word_sel;
  logic              rev_on;

  assign out_b    = take ? sel_b : boundary;
  assign word_sel = DATA_W'((hist >> (base + {2'b00, out_b}))
                            & lowmask({2'b00, wbits}));
  assign rev_on   = bit_order_reverse & basic & slip_mode & ~dbl;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out       <= '0;
      sync_status    <= 1'b0;
      pattern_detect <= 1'b0;
    end else if (ce) begin
      data_out       <= rev_on ? mirror(word_sel, ~w8)
                               : word_sel;
      pattern_detect <= next_pd;
      sync_status    <= slip_mode ? 1'b0 :
                        dbl ? (en_rise ? 1'b0 : (take | sync_level))
                            : next_sync_pulse;
    end
  end

  assign status_word = {23'h0, sync_level, armed, locked, 1'b0, boundary};

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_slip_edge;
    ce && slip_mode && slip_rise && (boundary < wbits - 5'd1);
  endsequence

  sequence s_en_rise_dbl;
    ce && dbl && !slip_mode && en_rise;
  endsequence

  a_slip_one_bit: assert property (
    s_slip_edge |=> boundary == $past(boundary) + 5'd1)
    else $error("Slip did not move boundary by one bit");

  a_w10_hold_low: assert property (
    ce && !slip_mode && wcode == WID_10 && !align_enable
    |=> boundary == $past(boundary))
    else $error("10-bit boundary moved with enable low");

  a_w8_needs_edge: assert property (
    ce && !slip_mode && w8 && !armed && !en_rise
    |=> boundary == $past(boundary))
    else $error("8-bit boundary moved without enable edge");

  a_dbl_sync_drop: assert property (
    s_en_rise_dbl ##1 (ce && !take)[*2] |-> !sync_status)
    else $error("Double width sync did not drop on enable rise");

  a_dbl_sync_hold: assert property (
    ce && dbl && !slip_mode && sync_level && !en_rise
    ##1 ce && !en_rise |-> sync_status)
    else $error("Double width sync fell without enable rise");

  a_sync_with_pd: assert property (
    !dbl && !slip_mode && sync_status |-> pattern_detect)
    else $error("Single width sync pulsed without pattern detect");

  a_slip_no_sync: assert property (
    ce && slip_mode |=> !sync_status)
    else $error("Sync raised in bit-slip mode");

  a_pd_has_cause: assert property (
    ce && !any_hit |=> !pattern_detect)
    else $error("Pattern detect without a match");

  a_reverse_map: assert property (
    ce && rev_on && w8 |=> data_out[0] == $past(word_sel[7])
                        && data_out[7] == $past(word_sel[0]))
    else $error("Bit reversal did not mirror the word");

  a_invert_path: assert property (
    ce && polarity_invert |=> hist[HIST_W-1] == !$past(rx_word[wbits-1]))
    else $error("Polarity inversion not applied");

endmodule

/* verif/rx_stream_source.sv */
// Far-side model: serialises queued bits into deserialised words
module rx_stream_source
  import rx_word_aligner_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [1:0]        width,
  output logic      [DATA_W-1:0] rx_word
);
  timeunit 1ns;
  timeprecision 1ps;

  logic              q[$];
  logic [DATA_W-1:0] fill = '0;
  logic              tog  = 1'b0;

  initial rx_word = '0;

  // Queue stream bits, oldest bit first
  task automatic put(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) q.push_back(v[i]);
  endtask

  // One word per edge, oldest bit in bit 0; unused bits carry noise
  always @(posedge clk) begin : emit
    int                w;
    logic [DATA_W-1:0] d;
    w = (width == WID_8) ? 8 : (width == WID_10) ? 10 :
        (width == WID_16) ? 16 : 20;
    tog <= ~tog;
    for (int i = 0; i < DATA_W; i++)
      d[i] = (i >= w) ? (tog ^ i[0]) : (q.size() > 0) ? q.pop_front() : fill[i];
    rx_word <= d;
  end
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the receive word aligner
module tb_top
  import rx_word_aligner_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              ce = 1'b1;
  logic              hsel = 1'b0;
  logic              hwrite = 1'b0;
  logic              hready;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       haddr = '0;
  logic [1:0]        htrans = '0;
  logic [2:0]        hsize = 3'h2;
  logic [31:0]       hwdata = '0;
  logic [31:0]       hrdata;
  logic [31:0]       rd;
  logic [DATA_W-1:0] rx_word;
  logic [DATA_W-1:0] data_out;
  logic [DATA_W-1:0] ex;
  logic              polarity_invert = 1'b0;
  logic              bit_order_reverse = 1'b0;
  logic              align_enable = 1'b0;
  logic              slip_request = 1'b0;
  logic              framing_size_select = 1'b0;
  logic              sync_status;
  logic              pattern_detect;
  logic [1:0]        wcode = WID_8;
  int                mismatches = 0;
  int                n_tests = 0;
  int                n_sync = 0;
  int                n_det = 0;
  int                n_both = 0;
  int                cycles = 0;
  int                wd = 8;

  assign hready = hreadyout;

  rx_word_aligner dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_word(rx_word), .polarity_invert(polarity_invert),
    .bit_order_reverse(bit_order_reverse), .align_enable(align_enable),
    .slip_request(slip_request), .framing_size_select(framing_size_select),
    .data_out(data_out), .sync_status(sync_status),
    .pattern_detect(pattern_detect)
  );

  rx_stream_source src (.clk(clk), .width(wcode), .rx_word(rx_word));

  // Clock, 5 ns period
  initial forever #2.5 clk = ~clk;

  // Status pulse counters and hang guard
  always @(posedge clk) begin
    cycles++;
    if (rst_n === 1'b1 && sync_status === 1'b1) n_sync++;
    if (rst_n === 1'b1 && pattern_detect === 1'b1) n_det++;
    if (rst_n === 1'b1 && (sync_status & pattern_detect) === 1'b1) n_both++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // One AHB-Lite single word transfer, waiting on hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic bnd(input logic [31:0] e);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk(rd & 32'h0000_001F, e);
  endtask

  task automatic chk_do(input logic [DATA_W-1:0] e);
    chk({12'h0, data_out}, {12'h0, e});
  endtask

  function automatic logic [DATA_W-1:0] rotr(input logic [DATA_W-1:0] v,
                                             input int k, input int w);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < w; i++) r[i] = v[(i + k) % w];
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] brev(input logic [DATA_W-1:0] v,
                                             input int w);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < w; i++) r[i] = v[w - 1 - i];
    return r;
  endfunction

  // Pattern placed sh bits into a word, padded to whole words of zeros
  task automatic frame(input logic [31:0] v, input int n, input int sh);
    int pad;
    pad = wd - (sh + n) % wd;
    src.put(32'h0, sh);
    src.put(v, n);
    src.put(32'h0, pad + 3 * wd);
    repeat ((sh + n + pad) / wd + 6) @(posedge clk);
  endtask

  // Enable rise, then dropped again to hold the boundary
  task automatic en_pulse();
    align_enable <= 1'b1;
    repeat (2) @(posedge clk);
    align_enable <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  // Main sequence
  initial begin
    do_reset();
    bus(1'b0, CTRL_OFS, 32'h0);
    chk(rd, CTRL_RESET);
    bus(1'b0, PATTERN_OFS, 32'h0);
    chk(rd, PAT_RESET);
    bus(1'b1, 8'h0C, 32'h1234_5678);
    bus(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0000_0000);
    bus(1'b1, CTRL_OFS, 32'hFFFF_FFFF);
    bus(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h0000_00FF);
    // 8-bit framing search, edge sensitive enable
    bus(1'b1, CTRL_OFS, 32'h0000_0040);
    // Drop pulses left from the all-ones control word
    repeat (2) @(posedge clk);
    n_det = 0;
    n_sync = 0;
    n_both = 0;
    frame(32'h28F6, 16, 3);
    chk(n_det + n_sync, 0);
    en_pulse();
    frame(32'h28F6, 16, 3);
    chk(n_both, 1);
    chk(n_det, 1);
    bnd(3);
    frame(32'h28F6, 16, 3);
    chk(n_det, 2);
    chk(n_sync, 1);
    frame(32'h28F6, 16, 5);
    chk(n_det + n_sync, 3);
    en_pulse();
    frame(32'h28F6, 16, 5);
    chk(n_both, 2);
    bnd(5);
    framing_size_select <= 1'b1;
    frame(32'h28F6, 16, 5);
    chk(n_det, 3);
    frame(32'h2828_F6F6, 32, 5);
    chk(n_det, 4);
    // Bit-slip at 8 and 10 bits on a constant word stream
    framing_size_select <= 1'b0;
    do_reset();
    bus(1'b1, PATTERN_OFS, 32'h0000_0F0F);
    for (int m = 0; m < 2; m++) begin
      wd = m ? 10 : 8;
      wcode <= m ? WID_10 : WID_8;
      src.fill = m ? 20'h003E0 : 20'h000F0;
      bus(1'b1, CTRL_OFS, m ? 32'h0000_0093 : 32'h0000_0099);
      repeat (4) @(posedge clk);
      for (int k = 1; k <= wd; k++) begin
        slip_request <= 1'b1;
        @(posedge clk);
        slip_request <= 1'b0;
        repeat (4) @(posedge clk);
        ex = rotr(src.fill, k % wd, wd);
        chk_do(ex);
        bnd(k % wd);
        if (m == 0) chk(pattern_detect, k == 4);
        if (k == 3) begin
          bit_order_reverse <= 1'b1;
          repeat (3) @(posedge clk);
          chk_do(brev(ex, wd));
          bit_order_reverse <= 1'b0;
          polarity_invert <= 1'b1;
          repeat (4) @(posedge clk);
          chk_do(ex ^ rotr('1, 0, wd));
          polarity_invert <= 1'b0;
          repeat (3) @(posedge clk);
        end
      end
    end
    // Reversal ignored outside bit-slip mode
    bus(1'b1, CTRL_OFS, 32'h0000_0092);
    bit_order_reverse <= 1'b1;
    repeat (4) @(posedge clk);
    chk_do(20'h003E0);
    bit_order_reverse <= 1'b0;
    // 10-bit level sensitive enable
    src.fill = '0;
    bus(1'b1, PATTERN_OFS, 32'h0000_017C);
    align_enable <= 1'b1;
    frame(32'h017C, 10, 4);
    bnd(4);
    align_enable <= 1'b0;
    frame(32'h017C, 10, 7);
    bnd(4);
    align_enable <= 1'b1;
    frame(32'h017C, 10, 7);
    bnd(7);
    align_enable <= 1'b0;
    // Mid-run reset, then double width lock
    do_reset();
    chk(sync_status, 1'b0);
    bnd(0);
    wd = 16;
    wcode <= WID_16;
    bus(1'b1, PATTERN_OFS, 32'h0000_ABCD);
    bus(1'b1, CTRL_OFS, 32'h0000_009C);
    frame(32'hABCD, 16, 3);
    chk(sync_status, 1'b1);
    bnd(3);
    frame(32'hABCD, 16, 7);
    chk(sync_status, 1'b1);
    bnd(3);
    en_pulse();
    chk(sync_status, 1'b0);
    frame(32'hABCD, 16, 7);
    chk(sync_status, 1'b1);
    bnd(7);
    conclude();
  end
endmodule
